// ===== verilog/option_shadow_pkg.sv
package option_shadow_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register file addresses of the shadow registers
  localparam logic [11:0] OPTION_BYTE_ZERO_SHADOW_ADDR = 12'hd0e;
  localparam logic [11:0] OPTION_BYTE_ONE_SHADOW_ADDR = 12'hd0f;
  localparam logic [11:0] PROT_STATUS_ADDR = 12'hd10;

  ////////////////////////////////////////////////////////////////////////////
  // information block addresses of the option bytes
  localparam logic [7:0] INFO_ADDR_OPTION_BYTE_ZERO = 8'hfe;
  localparam logic [7:0] INFO_ADDR_OPTION_BYTE_ONE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int WDT_POS        = 7;
  localparam int P4_PU_POS      = 6;
  localparam int P3_PU_POS      = 5;
  localparam int P2_PU_POS      = 4;
  localparam int P1H_PU_POS     = 3;
  localparam int P1L_PU_POS     = 2;
  localparam int P0H_PU_POS     = 1;
  localparam int P0L_PU_POS     = 0;
  localparam int STACK_POS      = 3;
  localparam int DIV_POS        = 2;
  localparam int LOWER_PROT_POS = 1;
  localparam int MAIN_PROT_POS  = 0;
  localparam int SRR_LOAD_POS   = 5;
  localparam int SRR_DIV_POS    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and masks
  localparam logic [7:0] OPTION_BYTE_ZERO_RESET         = 8'hff;
  localparam logic [1:0] OPTION_BYTE_ONE_CFG_RESET     = 2'b11;
  localparam logic [1:0] PROT_RESET         = 2'b11;
  localparam logic [1:0] PROT_UNLOCKED      = 2'b11;
  localparam logic [7:0] READ_ZERO          = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // fetch sequencer states
  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_BYTE0,
    FETCH_BYTE1
  } fetch_state_e;

endpackage : option_shadow_pkg

// ===== verilog/option_fetch_seq.sv
`timescale 1ns/100ps
module option_fetch_seq
  import option_shadow_pkg::*;
(
  // clock and reset
  input  logic       clk,
  input  logic       rst_n,
  // start of a reload
  input  logic       start,
  // information block read port
  output logic       info_rd_en,
  output logic [7:0] info_rd_addr,
  input  logic       info_rd_valid,
  // status to the shadow file
  output logic       busy,
  output logic       load0,
  output logic       load1
);

  fetch_state_e state;

  ////////////////////////////////////////////////////////////////////////////
  // power-on reset enters the fetch directly, so no load is ever skipped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FETCH_BYTE0;
    end else begin
      case (state)
        FETCH_IDLE: begin
          if (start) begin
            state <= FETCH_BYTE0;
          end
        end
        FETCH_BYTE0: begin
          if (info_rd_valid) begin
            state <= FETCH_BYTE1;
          end
        end
        FETCH_BYTE1: begin
          if (info_rd_valid) begin
            state <= FETCH_IDLE;
          end
        end
        default: begin
          state <= FETCH_IDLE;
        end
      endcase
    end
  end

  // address register follows the state one step ahead
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      info_rd_addr <= INFO_ADDR_OPTION_BYTE_ZERO;
    end else if (state == FETCH_BYTE0 && info_rd_valid) begin
      info_rd_addr <= INFO_ADDR_OPTION_BYTE_ONE;
    end else if (state == FETCH_IDLE) begin
      info_rd_addr <= INFO_ADDR_OPTION_BYTE_ZERO;
    end
  end

  // handshake terms
  assign busy       = (state != FETCH_IDLE);
  assign info_rd_en = busy;
  assign load0      = (state == FETCH_BYTE0) && info_rd_valid;
  assign load1      = (state == FETCH_BYTE1) && info_rd_valid;

endmodule : option_fetch_seq

// ===== verilog/protect_latch.sv
`timescale 1ns/100ps
module protect_latch
  import option_shadow_pkg::*;
(
  // clock and reset
  input  logic       clk,
  input  logic       rst_n,
  // capture at power-on load
  input  logic       capture,
  input  logic [1:0] capture_bits,
  // completed main-memory mass erase
  input  logic       mass_erase_done,
  // protection state, 0 means protected
  output logic [1:0] prot_bits
);

  ////////////////////////////////////////////////////////////////////////////
  // no software path reaches these flops; erase wins over a same-cycle capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_bits <= PROT_RESET;
    end else if (mass_erase_done) begin
      prot_bits <= PROT_UNLOCKED;
    end else if (capture) begin
      prot_bits <= capture_bits;
    end
  end

endmodule : protect_latch

// ===== verilog/flash_option_shadow_loader.sv
`timescale 1ns/100ps
// Overview of operation
// - every option bit has a shadow flop; features read shadows, not flash
// - flash option changes take effect only after a reloading reset
// - power-on reset loads shadows; stop recovery loads only with recovery bit 5 set
// - shadows needing a value are preset at reset start until loaded
// - option byte 0 fetched from address FEh, byte 1 from FFh
// - cpu reads/writes all shadows except byte 1 bits 1:0, which are read-only
// - shadow outputs are meaningless until loaded; consumers must wait
// - byte 0 bit 7 one means instruction-started watchdog, zero always on
// - byte 0 bits 6:0 are active-low pull-up enables per port group
// - option byte 1 page is modified only through the in-circuit port
// - power-on reset captures byte 1 bits 1:0 into readable protection flops
// - software never writes protection flops; only capture or mass erase
// - byte 1 bit 3 zero selects sixteen-bit stack pointer
// - byte 1 bit 2 with recovery bit 0 picks undivided crystal clock
// - byte 1 bit 1 zero protects lower half of main memory
// - an option bit protects all main memory from external interfaces
// - bit 0 zero blocks main access and page 3 changes; mass erase clears it
// - clock divide shadow resets to one; bits 7:4 read zero, ignore writes
module flash_option_shadow_loader
  import option_shadow_pkg::*;
(
  // clock and power-on reset
  input  logic        clk,
  input  logic        rst_n,
  // stop-mode recovery reset
  input  logic        stop_recovery_reset,
  input  logic [7:0]  stop_recovery_register,
  // information block read port
  output logic        info_rd_en,
  output logic [7:0]  info_rd_addr,
  input  logic        info_rd_valid,
  input  logic [7:0]  info_rd_data,
  // cpu register file port
  input  logic [11:0] reg_addr,
  input  logic        reg_wr_en,
  input  logic        reg_rd_en,
  input  logic [7:0]  reg_wdata,
  output logic [7:0]  reg_rdata,
  // flash programming access check
  input  logic        mass_erase_done,
  input  logic        prog_req,
  input  logic        prog_via_icp,
  input  logic        prog_main,
  input  logic        prog_lower_half,
  input  logic        prog_page3_modify,
  output logic        prog_grant,
  // reset and configuration outputs
  output logic        internal_reset_n,
  output logic        watchdog_policy_bit,
  output logic        port4_pullup_enable_n,
  output logic        port3_pullup_enable_n,
  output logic        port2_pullup_enable_n,
  output logic        port1_high_pullup_enable_n,
  output logic        port1_low_pullup_enable_n,
  output logic        port0_high_pullup_enable_n,
  output logic        port0_low_pullup_enable_n,
  output logic        wide_stack_select,
  output logic        clock_undivided_select,
  output logic        lower_half_protect,
  output logic        main_memory_protect
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] option_byte_zero;
  logic [1:0] option_byte_one_cfg;
  logic [1:0] prot_bits;
  logic       busy;
  logic       load0;
  logic       load1;
  logic       smr_load;
  logic       por_load;
  logic       wr_option_byte_zero;
  logic       wr_option_byte_one;

  // address decode shared by write and read paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction : hit

  assign wr_option_byte_zero  = reg_wr_en && hit(reg_addr, OPTION_BYTE_ZERO_SHADOW_ADDR);
  assign wr_option_byte_one  = reg_wr_en && hit(reg_addr, OPTION_BYTE_ONE_SHADOW_ADDR);
  assign smr_load = stop_recovery_reset && stop_recovery_register[SRR_LOAD_POS] && !busy;

  ////////////////////////////////////////////////////////////////////////////
  // fetch sequencer: two reads from the top of the information block
  option_fetch_seq u_fetch (
    .clk           (clk),
    .rst_n         (rst_n),
    .start         (smr_load),
    .info_rd_en    (info_rd_en),
    .info_rd_addr  (info_rd_addr),
    .info_rd_valid (info_rd_valid),
    .busy          (busy),
    .load0         (load0),
    .load1         (load1)
  );

  // remembers that the running load belongs to power-on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_load <= 1'b1;
    end else if (load1) begin
      por_load <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection flops, captured only by the power-on load
  protect_latch u_prot (
    .clk             (clk),
    .rst_n           (rst_n),
    .capture         (load1 && por_load),
    .capture_bits    (info_rd_data[LOWER_PROT_POS:MAIN_PROT_POS]),
    .mass_erase_done (mass_erase_done),
    .prot_bits       (prot_bits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // option byte 0 shadow; reset value matches an erased byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      option_byte_zero <= OPTION_BYTE_ZERO_RESET;
    end else if (load0) begin
      option_byte_zero <= info_rd_data;
    end else if (wr_option_byte_zero) begin
      option_byte_zero <= reg_wdata;
    end
  end

  // option byte 1 writable bits; divide bit preset at reset start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      option_byte_one_cfg <= OPTION_BYTE_ONE_CFG_RESET;
    end else if (smr_load) begin
      option_byte_one_cfg[DIV_POS - STACK_POS + 1] <= 1'b1;
    end else if (load1) begin
      option_byte_one_cfg <= info_rd_data[STACK_POS:DIV_POS];
    end else if (wr_option_byte_one) begin
      option_byte_one_cfg <= reg_wdata[STACK_POS:DIV_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal reset held while the loader runs, so nobody sees stale shadows
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      internal_reset_n <= 1'b0;
    end else begin
      internal_reset_n <= !busy && !smr_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port; reserved bits read zero, bits 1:0 show protection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd_en) begin
      if (hit(reg_addr, OPTION_BYTE_ZERO_SHADOW_ADDR)) begin
        reg_rdata <= option_byte_zero;
      end else if (hit(reg_addr, OPTION_BYTE_ONE_SHADOW_ADDR)) begin
        reg_rdata <= {4'h0, option_byte_one_cfg, prot_bits};
      end else if (hit(reg_addr, PROT_STATUS_ADDR)) begin
        reg_rdata <= {6'h00, prot_bits};
      end else begin
        reg_rdata <= READ_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // feature outputs straight from the shadows, never from flash
  assign watchdog_policy_bit        = option_byte_zero[WDT_POS];
  assign port4_pullup_enable_n      = option_byte_zero[P4_PU_POS];
  assign port3_pullup_enable_n      = option_byte_zero[P3_PU_POS];
  assign port2_pullup_enable_n      = option_byte_zero[P2_PU_POS];
  assign port1_high_pullup_enable_n = option_byte_zero[P1H_PU_POS];
  assign port1_low_pullup_enable_n  = option_byte_zero[P1L_PU_POS];
  assign port0_high_pullup_enable_n = option_byte_zero[P0H_PU_POS];
  assign port0_low_pullup_enable_n  = option_byte_zero[P0L_PU_POS];

  // byte 1 features; index 1 of cfg is bit 3, index 0 is bit 2
  assign wide_stack_select      = !option_byte_one_cfg[1];
  assign clock_undivided_select = !option_byte_one_cfg[0] &&
                                  !stop_recovery_register[SRR_DIV_POS];
  assign lower_half_protect     = !prot_bits[LOWER_PROT_POS];
  assign main_memory_protect    = !prot_bits[MAIN_PROT_POS];

  ////////////////////////////////////////////////////////////////////////////
  // programming access filter; only the in-circuit port may touch page 3
  assign prog_grant = prog_req
                   && !(prog_page3_modify && !prog_via_icp)
                   && !((prog_main || prog_page3_modify) && main_memory_protect)
                   && !(prog_main && prog_lower_half && lower_half_protect);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_reset_held;
    busy |-> ##1 !internal_reset_n;
  endproperty
  a_reset_held: assert property (p_reset_held) else $error("reset released during load");

  property p_first_addr;
    $rose(busy) |-> info_rd_addr == INFO_ADDR_OPTION_BYTE_ZERO && info_rd_en;
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("load not from FEh");

  property p_second_addr;
    load0 |=> info_rd_addr == INFO_ADDR_OPTION_BYTE_ONE;
  endproperty
  a_second_addr: assert property (p_second_addr) else $error("byte 1 not from FFh");

  property p_load0;
    load0 |=> option_byte_zero == $past(info_rd_data) && watchdog_policy_bit == $past(info_rd_data[7]);
  endproperty
  a_load0: assert property (p_load0) else $error("byte 0 shadow not loaded");

  property p_stable0;
    !load0 && !wr_option_byte_zero |=> $stable(option_byte_zero);
  endproperty
  a_stable0: assert property (p_stable0) else $error("byte 0 shadow changed unprompted");

  property p_smr_noload;
    stop_recovery_reset && !stop_recovery_register[5] && !busy |=> !busy;
  endproperty
  a_smr_noload: assert property (p_smr_noload) else $error("reload without bit 5");

  property p_div_preset;
    smr_load |=> option_byte_one_cfg[0] && !internal_reset_n;
  endproperty
  a_div_preset: assert property (p_div_preset) else $error("divide bit not preset");

  property p_prot_locked;
    !mass_erase_done && !(load1 && por_load) |=> $stable(prot_bits);
  endproperty
  a_prot_locked: assert property (p_prot_locked) else $error("protection flops changed");

  property p_mass_erase;
    mass_erase_done |=> !main_memory_protect ##0 !lower_half_protect;
  endproperty
  a_mass_erase: assert property (p_mass_erase) else $error("mass erase did not unlock");

  property p_block_main;
    main_memory_protect && prog_main |-> !prog_grant;
  endproperty
  a_block_main: assert property (p_block_main) else $error("protected main access granted");

  property p_page3_icp;
    prog_grant && prog_page3_modify |-> prog_via_icp;
  endproperty
  a_page3_icp: assert property (p_page3_icp) else $error("page 3 change off the port");

  property p_rsvd_read;
    reg_rd_en && reg_addr == OPTION_BYTE_ONE_SHADOW_ADDR |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits not zero");

  property p_stack;
    load1 |=> wide_stack_select == !$past(info_rd_data[3]);
  endproperty
  a_stack: assert property (p_stack) else $error("stack select wrong");

  property p_clkdiv;
    clock_undivided_select |-> !option_byte_one_cfg[0] && !stop_recovery_register[0];
  endproperty
  a_clkdiv: assert property (p_clkdiv) else $error("undivided clock wrongly chosen");

  // main scenarios
  c_por_load: cover property ($rose(internal_reset_n));
  c_smr_load: cover property (smr_load ##[1:20] load1);
  c_mass:     cover property (main_memory_protect ##1 mass_erase_done);
  c_cpu_wr:   cover property (wr_option_byte_one ##1 reg_rd_en);

endmodule : flash_option_shadow_loader

// ===== testbench/info_block_model.sv
`timescale 1ns/100ps
module info_block_model
  import option_shadow_pkg::*;
(
  // clock and reset
  input  logic       clk,
  input  logic       rst_n,
  // read port facing the loader
  input  logic       info_rd_en,
  input  logic [7:0] info_rd_addr,
  output logic       info_rd_valid,
  output logic [7:0] info_rd_data,
  // stored bytes and answer speed
  input  logic [7:0] byte_zero,
  input  logic [3:0] byte_one_low,
  input  logic [3:0] wait_cycles
);
  logic [3:0] count;
  logic [7:0] word;

  ////////////////////////////////////////////////////////////
  // contents of the top two bytes, the rest reads erased
  always_comb begin
    case (info_rd_addr)
      INFO_ADDR_OPTION_BYTE_ZERO: word = byte_zero;
      INFO_ADDR_OPTION_BYTE_ONE: word = {4'hf, byte_one_low};
      default:        word = 8'hff;
    endcase
  end

  // answer after a set wait; data toggles outside the strobe so stale bytes never match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count         <= '0;
      info_rd_valid <= 1'b0;
      info_rd_data  <= 8'h5a;
    end else if (info_rd_en && !info_rd_valid && count >= wait_cycles) begin
      count         <= '0;
      info_rd_valid <= 1'b1;
      info_rd_data  <= word;
    end else begin
      count         <= (info_rd_en && !info_rd_valid) ? count + 4'd1 : 4'd0;
      info_rd_valid <= 1'b0;
      info_rd_data  <= ~info_rd_data;
    end
  end
endmodule : info_block_model

// ===== testbench/flash_option_shadow_loader_tb.sv
`timescale 1ns/100ps
module flash_option_shadow_loader_tb
  import option_shadow_pkg::*;
;
  logic        clk, rst_n, stop_recovery_reset, info_rd_en, info_rd_valid;
  logic        reg_wr_en, reg_rd_en, mass_erase_done, prog_req, prog_via_icp;
  logic        prog_main, prog_lower_half, prog_page3_modify, prog_grant;
  logic        internal_reset_n, watchdog_policy_bit, wide_stack_select;
  logic        clock_undivided_select, lower_half_protect, main_memory_protect;
  logic [6:0]  pu;
  logic [7:0]  stop_recovery_register, info_rd_addr, info_rd_data, reg_wdata, reg_rdata;
  logic [7:0]  byte_zero;
  logic [3:0]  byte_one_low, wait_cycles;
  logic [11:0] reg_addr;
  logic [15:0] seen;
  int          bad_count, check_count;

  ////////////////////////////////////////////////////////////
  flash_option_shadow_loader i_dut (
    .clk(clk), .rst_n(rst_n), .stop_recovery_reset(stop_recovery_reset),
    .stop_recovery_register(stop_recovery_register), .info_rd_en(info_rd_en),
    .info_rd_addr(info_rd_addr), .info_rd_valid(info_rd_valid), .info_rd_data(info_rd_data),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mass_erase_done(mass_erase_done),
    .prog_req(prog_req), .prog_via_icp(prog_via_icp), .prog_main(prog_main),
    .prog_lower_half(prog_lower_half), .prog_page3_modify(prog_page3_modify),
    .prog_grant(prog_grant), .internal_reset_n(internal_reset_n),
    .watchdog_policy_bit(watchdog_policy_bit), .port4_pullup_enable_n(pu[6]),
    .port3_pullup_enable_n(pu[5]), .port2_pullup_enable_n(pu[4]),
    .port1_high_pullup_enable_n(pu[3]), .port1_low_pullup_enable_n(pu[2]),
    .port0_high_pullup_enable_n(pu[1]), .port0_low_pullup_enable_n(pu[0]),
    .wide_stack_select(wide_stack_select), .clock_undivided_select(clock_undivided_select),
    .lower_half_protect(lower_half_protect), .main_memory_protect(main_memory_protect));

  info_block_model i_info (
    .clk(clk), .rst_n(rst_n), .info_rd_en(info_rd_en), .info_rd_addr(info_rd_addr),
    .info_rd_valid(info_rd_valid), .info_rd_data(info_rd_data), .byte_zero(byte_zero),
    .byte_one_low(byte_one_low), .wait_cycles(wait_cycles));

  // 100 MHz clock; log fetched addresses in answer order
  always #5 clk = ~clk;
  always @(posedge clk) if (info_rd_valid) seen <= {seen[7:0], info_rd_addr};

  ////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk1

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clk);
    #1 reg_wr_en = 1'b0;
    // idle cycle so a following strobe never rises in the same step
    @(posedge clk);
    #1;
  endtask : reg_wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clk);
    #1 reg_rd_en = 1'b0;
    chk8(reg_rdata, exp);
    @(posedge clk);
    #1;
  endtask : rd_chk

  // bounded wait for the load to finish, then fetch must be idle
  task automatic wait_ready();
    int n;
    n = 0;
    while (internal_reset_n !== 1'b1 && n < 80) begin
      @(posedge clk);
      #1 n++;
    end
    chk1(internal_reset_n, 1'b1);
    chk1(info_rd_en, 1'b0);
  endtask : wait_ready

  task automatic por(input logic [7:0] b0, input logic [3:0] b1);
    rst_n = 1'b0;
    byte_zero = b0;
    byte_one_low = b1;
    repeat (8) @(posedge clk);
    #1 chk1(watchdog_policy_bit, 1'b1);
    chk1(clock_undivided_select, 1'b0);
    rst_n = 1'b1;
    wait_ready();
  endtask : por

  task automatic access(input logic v, m, l, p, exp);
    {prog_req, prog_via_icp, prog_main, prog_lower_half, prog_page3_modify} = {1'b1, v, m, l, p};
    #1 chk1(prog_grant, exp);
    prog_req = 1'b0;
    @(posedge clk);
    #1;
  endtask : access

  task automatic srr_pulse(input logic [7:0] v, input logic exp);
    stop_recovery_register = v;
    stop_recovery_reset = 1'b1;
    @(posedge clk);
    #1 stop_recovery_reset = 1'b0;
    @(posedge clk);
    #1 chk1(internal_reset_n, exp);
  endtask : srr_pulse

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////
  task automatic t_por_load();
    por(8'h5a, 4'b0110);
    chk8(seen[15:8], INFO_ADDR_OPTION_BYTE_ZERO);
    chk8(seen[7:0], INFO_ADDR_OPTION_BYTE_ONE);
    chk8({watchdog_policy_bit, pu}, 8'h5a);
    chk1(wide_stack_select, 1'b1);
    chk1(clock_undivided_select, 1'b0);
    chk1(main_memory_protect, 1'b1);
    chk1(lower_half_protect, 1'b0);
    rd_chk(OPTION_BYTE_ZERO_SHADOW_ADDR, 8'h5a);
    rd_chk(OPTION_BYTE_ONE_SHADOW_ADDR, 8'h06);
    rd_chk(PROT_STATUS_ADDR, 8'h02);
    access(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    access(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    $display("test por_load done");
  endtask : t_por_load

  task automatic t_reg_access();
    reg_wr(OPTION_BYTE_ZERO_SHADOW_ADDR, 8'h3c);
    chk8({watchdog_policy_bit, pu}, 8'h3c);
    rd_chk(OPTION_BYTE_ZERO_SHADOW_ADDR, 8'h3c);
    reg_wr(OPTION_BYTE_ONE_SHADOW_ADDR, 8'hff);
    rd_chk(OPTION_BYTE_ONE_SHADOW_ADDR, 8'h0e);
    chk1(main_memory_protect, 1'b1);
    reg_wr(PROT_STATUS_ADDR, 8'h03);
    rd_chk(PROT_STATUS_ADDR, 8'h02);
    rd_chk(12'h123, 8'h00);
    byte_zero = 8'hff;
    repeat (4) @(posedge clk);
    #1 rd_chk(OPTION_BYTE_ZERO_SHADOW_ADDR, 8'h3c);
    $display("test reg_access done");
  endtask : t_reg_access

  task automatic t_stop_recovery();
    srr_pulse(8'h01, 1'b1);
    rd_chk(OPTION_BYTE_ZERO_SHADOW_ADDR, 8'h3c);
    byte_one_low = 4'b0011;
    wait_cycles = 4'd7;
    srr_pulse(8'h20, 1'b0);
    chk1(clock_undivided_select, 1'b0);
    wait_ready();
    chk8({watchdog_policy_bit, pu}, 8'hff);
    chk1(clock_undivided_select, 1'b1);
    stop_recovery_register = 8'h21;
    #1 chk1(clock_undivided_select, 1'b0);
    rd_chk(OPTION_BYTE_ONE_SHADOW_ADDR, 8'h02);
    $display("test stop_recovery done");
  endtask : t_stop_recovery

  task automatic t_protect();
    stop_recovery_register = 8'h00;
    wait_cycles = 4'd1;
    por(8'hff, 4'b1101);
    chk1(lower_half_protect, 1'b1);
    chk1(wide_stack_select, 1'b0);
    access(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    access(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    access(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    mass_erase_done = 1'b1;
    @(posedge clk);
    #1 mass_erase_done = 1'b0;
    chk1(lower_half_protect, 1'b0);
    rd_chk(PROT_STATUS_ADDR, 8'h03);
    access(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    access(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("test protect done");
  endtask : t_protect

  ////////////////////////////////////////////////////////////
  // watchdog sized well above the roughly one hundred cycles the tests need
  initial begin
    #20000;
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {clk, stop_recovery_reset, reg_wr_en, reg_rd_en, mass_erase_done} = '0;
    {prog_req, prog_via_icp, prog_main, prog_lower_half, prog_page3_modify} = '0;
    {stop_recovery_register, reg_wdata, reg_addr, seen} = '0;
    {bad_count, check_count} = '0;
    wait_cycles = 4'd3;
    rst_n = 1'b0;
    byte_zero = 8'hff;
    byte_one_low = 4'hf;
    @(posedge clk);
    #1 t_por_load();
    t_reg_access();
    t_stop_recovery();
    t_protect();
    end_of_test();
  end
endmodule : flash_option_shadow_loader_tb
